// [common/ebus_defs.svh]
/*
  Constants for the external memory and I/O bus pin controller.
  Assumes a single 25 MHz clock and an active low asynchronous reset.
*/
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define EBUS_ADDR_W 23
`define EBUS_ADDR_LO_W 16
`define EBUS_DATA_W 16
`define EBUS_WS_W 3

// ---------------------------------------------------------------------------
// Values
// ---------------------------------------------------------------------------
`define EBUS_READY_MIN_WS 3'h2
`define EBUS_WS_ZERO 3'h0
`define EBUS_WS_STEP 3'h1
`define EBUS_PIN_IDLE 1'b1
`define EBUS_PIN_ACTIVE 1'b0
`define EBUS_HI_ADDR_IDLE 7'h00
`define EBUS_KEEPER_RESET 1'b0

`endif

// [common/ebus_pkg.sv]
/*
  Types for the external bus pin controller and its data keeper.
  Assumes ebus_defs.svh is reachable on the include path.
*/
`include "ebus_defs.svh"

package ebus_pkg;

  // -------------------------------------------------------------------------
  // Access request from the core
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} space_type;

  typedef struct packed {
    logic valid;
    space_type space;
    logic write;
    logic vector_fetch;
    logic [`EBUS_WS_W-1:0] wait_states;
    logic [`EBUS_ADDR_W-1:0] addr;
    logic [`EBUS_DATA_W-1:0] wdata;
  } bus_req_type;

  // -------------------------------------------------------------------------
  // Pin outputs, each with its enable
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [`EBUS_ADDR_W-1:0] ext_addr;
    logic addr_lo_oe;
    logic addr_hi_oe;
    logic [`EBUS_DATA_W-1:0] ext_data;
    logic data_oe;
    logic data_space_select_n;
    logic program_space_select_n;
    logic io_space_select_n;
    logic memory_strobe_n;
    logic io_strobe_n;
    logic read_write;
    logic ctl_oe;
    logic irq_acknowledge_n;
    logic irq_ack_oe;
  } bus_pins_type;

  typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_HELD} phase_type;

  typedef struct packed {
    phase_type phase;
    space_type space;
    logic write;
    logic [`EBUS_WS_W-1:0] ws_count;
    logic [`EBUS_WS_W-1:0] ws_total;
    logic busy;
    logic done;
    logic [`EBUS_DATA_W-1:0] rdata;
    logic bus_release_grant_n;
    bus_pins_type pins;
  } ctl_state_type;

  typedef struct packed {
    logic enable;
    logic hold_en;
    logic [`EBUS_DATA_W-1:0] hold_val;
  } keeper_state_type;

endpackage

// [rtl/ebus_keeper.sv]
/*
  Data bus keeper: remembers the last level of each data line and asks
  the pad to hold it while nobody drives. Assumes the pad resolves
  hold_en_out and hold_val_out as a weak drive.
*/
`include "ebus_defs.svh"
module ebus_keeper (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic keeper_wr_in,
  input wire logic bus_keeper_enable_in,
  input wire logic drive_next_in,
  input wire logic [`EBUS_DATA_W-1:0] drive_val_in,
  input wire logic [`EBUS_DATA_W-1:0] ext_data_in,
  output logic keeper_on_out,
  output logic hold_en_out,
  output logic [`EBUS_DATA_W-1:0] hold_val_out
);
  import ebus_pkg::*;

  keeper_state_type s_q;
  keeper_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (keeper_wr_in) begin
      s_d.enable = bus_keeper_enable_in;
    end
    // Track the resolved level, own drive first
    s_d.hold_val = drive_next_in ? drive_val_in : ext_data_in;
    s_d.hold_en = s_d.enable && !drive_next_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{enable: `EBUS_KEEPER_RESET, hold_en: `EBUS_KEEPER_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign keeper_on_out = s_q.enable;
  assign hold_en_out = s_q.hold_en;
  assign hold_val_out = s_q.hold_val;

  default clocking kcb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_keeper_needs_enable: assert property (hold_en_out |-> keeper_on_out)
    else $error("keeper holds while disabled");
  a_keeper_write_takes: assert property (keeper_wr_in |=> keeper_on_out == $past(bus_keeper_enable_in))
    else $error("keeper enable write lost");
endmodule // ebus_keeper

// [rtl/ebus_ctrl.sv]
/*
  External memory and I/O bus pin controller: runs one access at a time,
  handles wait states, ready, bus release and global float.
  Assumes the core holds a request until busy_out rises and pads resolve
  every output enable into the real pin level.
*/
`include "ebus_defs.svh"
module ebus_ctrl (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire ebus_pkg::bus_req_type req_in,
  input wire logic ready_in,
  input wire logic bus_release_req_n_in,
  input wire logic off_n_in,
  input wire logic keeper_wr_in,
  input wire logic bus_keeper_enable_in,
  input wire logic [`EBUS_DATA_W-1:0] ext_data_in,
  output ebus_pkg::bus_pins_type pins_out,
  output logic bus_release_grant_n_out,
  output logic busy_out,
  output logic done_out,
  output logic [`EBUS_DATA_W-1:0] rdata_out,
  output logic keeper_on_out,
  output logic keeper_hold_en_out,
  output logic [`EBUS_DATA_W-1:0] keeper_hold_val_out
);
  import ebus_pkg::*;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Select lines for a space, order data, program, I/O
  function automatic logic [2:0] select_for(input space_type sp, input logic active);
    logic [2:0] sel;
    sel = {3{`EBUS_PIN_IDLE}};
    if (active) begin
      if (sp == SPACE_DATA) begin
        sel[2] = `EBUS_PIN_ACTIVE;
      end else if (sp == SPACE_PROG) begin
        sel[1] = `EBUS_PIN_ACTIVE;
      end else begin
        sel[0] = `EBUS_PIN_ACTIVE;
      end
    end
    return sel;
  endfunction

  function automatic logic ready_checked(input logic [`EBUS_WS_W-1:0] ws);
    return ws >= `EBUS_READY_MIN_WS;
  endfunction

  localparam ctl_state_type STATE_RESET = '{
    phase: PH_IDLE,
    space: SPACE_PROG,
    bus_release_grant_n: `EBUS_PIN_IDLE,
    pins: '{
      data_space_select_n: `EBUS_PIN_IDLE,
      program_space_select_n: `EBUS_PIN_IDLE,
      io_space_select_n: `EBUS_PIN_IDLE,
      memory_strobe_n: `EBUS_PIN_IDLE,
      io_strobe_n: `EBUS_PIN_IDLE,
      read_write: `EBUS_PIN_IDLE,
      irq_acknowledge_n: `EBUS_PIN_IDLE,
      default: '0
    },
    default: '0
  };

  ctl_state_type s_q;
  ctl_state_type s_d;
  logic in_access;
  logic floated;

  // -------------------------------------------------------------------------
  // Sequencing
  // -------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.phase)
      PH_IDLE: begin
        // Release only from idle, so an access never gets cut
        if (!bus_release_req_n_in) begin
          s_d.phase = PH_HELD;
          s_d.bus_release_grant_n = `EBUS_PIN_ACTIVE;
        end else if (req_in.valid) begin
          s_d.phase = PH_ACCESS;
          s_d.busy = 1'b1;
          s_d.space = req_in.space;
          s_d.write = req_in.write;
          s_d.ws_count = req_in.wait_states;
          s_d.ws_total = req_in.wait_states;
          s_d.pins.ext_addr = req_in.addr;
          if (req_in.space != SPACE_PROG) begin
            s_d.pins.ext_addr[`EBUS_ADDR_W-1:`EBUS_ADDR_LO_W] = `EBUS_HI_ADDR_IDLE;
          end
          s_d.pins.ext_data = req_in.wdata;
          {s_d.pins.data_space_select_n, s_d.pins.program_space_select_n,
           s_d.pins.io_space_select_n} = select_for(req_in.space, 1'b1);
          s_d.pins.memory_strobe_n = (req_in.space == SPACE_IO);
          s_d.pins.io_strobe_n = (req_in.space != SPACE_IO);
          s_d.pins.read_write = !req_in.write;
          s_d.pins.irq_acknowledge_n = !(req_in.vector_fetch && req_in.space == SPACE_PROG);
        end
      end
      PH_ACCESS: begin
        if (s_q.ws_count != `EBUS_WS_ZERO) begin
          s_d.ws_count = s_q.ws_count - `EBUS_WS_STEP;
        end else if (ready_checked(s_q.ws_total) && !ready_in) begin
          // Stay one more cycle and look again
          s_d.phase = PH_ACCESS;
        end else begin
          s_d.phase = PH_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.rdata = ext_data_in;
          {s_d.pins.data_space_select_n, s_d.pins.program_space_select_n,
           s_d.pins.io_space_select_n} = select_for(s_q.space, 1'b0);
          s_d.pins.memory_strobe_n = `EBUS_PIN_IDLE;
          s_d.pins.io_strobe_n = `EBUS_PIN_IDLE;
          s_d.pins.read_write = `EBUS_PIN_IDLE;
          s_d.pins.irq_acknowledge_n = `EBUS_PIN_IDLE;
        end
      end
      PH_HELD: begin
        if (bus_release_req_n_in) begin
          s_d.phase = PH_IDLE;
          s_d.bus_release_grant_n = `EBUS_PIN_IDLE;
        end
      end
      default: begin
        s_d = STATE_RESET;
      end
    endcase
    // Pad enables follow the next state so pins and enables move together
    in_access = (s_d.phase == PH_ACCESS);
    floated = !off_n_in || (s_d.phase == PH_HELD);
    s_d.pins.ctl_oe = !floated;
    s_d.pins.addr_lo_oe = !floated;
    s_d.pins.addr_hi_oe = !floated && in_access && (s_d.space == SPACE_PROG);
    s_d.pins.data_oe = !floated && in_access && s_d.write;
    s_d.pins.irq_ack_oe = off_n_in;
  end

  // Reset forces every enable low, so the data bus floats in reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign pins_out = s_q.pins;
  assign bus_release_grant_n_out = s_q.bus_release_grant_n;
  assign busy_out = s_q.busy;
  assign done_out = s_q.done;
  assign rdata_out = s_q.rdata;

  // Keeper sees next drive state, avoiding a one cycle gap at turnaround
  ebus_keeper u_keeper (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .keeper_wr_in(keeper_wr_in),
    .bus_keeper_enable_in(bus_keeper_enable_in),
    .drive_next_in(s_d.pins.data_oe),
    .drive_val_in(s_d.pins.ext_data),
    .ext_data_in(ext_data_in),
    .keeper_on_out(keeper_on_out),
    .hold_en_out(keeper_hold_en_out),
    .hold_val_out(keeper_hold_val_out)
  );

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_release_floats_bus: assert property (
    !bus_release_grant_n_out |-> !pins_out.addr_lo_oe && !pins_out.data_oe && !pins_out.ctl_oe)
    else $error("bus driven while released");

  a_float_input_floats: assert property (
    !off_n_in |=> !pins_out.addr_lo_oe && !pins_out.addr_hi_oe && !pins_out.data_oe)
    else $error("address or data driven under global float");

  a_irq_acknowledge_n_float_off: assert property (
    !off_n_in |=> !pins_out.irq_ack_oe)
    else $error("interrupt acknowledge driven under global float");

  a_data_drive_write: assert property (
    pins_out.data_oe |-> !pins_out.read_write && busy_out)
    else $error("data bus driven outside a write");

  a_write_low_only: assert property (
    !pins_out.read_write |-> busy_out && !pins_out.memory_strobe_n ^ !pins_out.io_strobe_n)
    else $error("direction low outside a write access");

  a_upper_addr_prog: assert property (
    pins_out.addr_hi_oe |-> !pins_out.program_space_select_n)
    else $error("upper address driven outside program access");

  a_select_one_low: assert property (
    (!pins_out.data_space_select_n || !pins_out.program_space_select_n || !pins_out.io_space_select_n)
    |-> busy_out && $onehot({!pins_out.data_space_select_n, !pins_out.program_space_select_n,
                             !pins_out.io_space_select_n}))
    else $error("space select low without a single access");

  a_irq_acknowledge_n_vector_fetch: assert property (
    !pins_out.irq_acknowledge_n |-> !pins_out.program_space_select_n && pins_out.read_write)
    else $error("interrupt acknowledge outside a vector fetch");

  a_ready_stall: assert property (
    busy_out && s_q.ws_count == `EBUS_WS_ZERO && ready_checked(s_q.ws_total) && !ready_in
    |=> busy_out && !done_out)
    else $error("access ended while ready low");

  a_ready_ignored: assert property (
    busy_out && s_q.ws_count == `EBUS_WS_ZERO && !ready_checked(s_q.ws_total) |=> done_out && !busy_out)
    else $error("ready honoured with fewer than two wait states");

  a_grant_after_idle: assert property (
    $fell(bus_release_grant_n_out) |-> !$past(busy_out))
    else $error("bus released during an access");

  a_wait_count_time: assert property (
    $rose(busy_out) && s_q.ws_total == `EBUS_READY_MIN_WS |-> ##2 busy_out ##1 (done_out || !$past(ready_in)))
    else $error("wait states not counted");

endmodule // ebus_ctrl

// [dv/ebus_mem_model.sv]
/*
  Far-side memory and I/O model for the bus pin controller.
  Assumes the bench resolves the data bus and feeds it back as data_in.
*/
`include "ebus_defs.svh"

module ebus_mem_model (
  input wire logic clk_in,
  input wire ebus_pkg::bus_pins_type pins_in,
  input wire logic [`EBUS_DATA_W-1:0] data_in,
  input wire logic [3:0] lag_in,
  output logic ready_out,
  output logic mem_oe_out,
  output logic [`EBUS_DATA_W-1:0] mem_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebus_pkg::*;
  // ---------------------------------------------------------------
  // Storage, one word per low address byte
  // ---------------------------------------------------------------
  logic [`EBUS_DATA_W-1:0] mem [0:255];
  logic [3:0] cnt;
  logic act;
  assign act = pins_in.ctl_oe && !(pins_in.memory_strobe_n && pins_in.io_strobe_n);
  // Slow device holds ready low for its first lag cycles
  assign ready_out = !(act && cnt < lag_in);
  assign mem_oe_out = act && pins_in.read_write;
  assign mem_data_out = mem[pins_in.ext_addr[7:0]];
  always @(posedge clk_in) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (act && !pins_in.read_write) begin
      mem[pins_in.ext_addr[7:0]] <= data_in;
    end
  end
endmodule // ebus_mem_model

// [dv/ebus_ctrl_bench.sv]
/*
  Self-checking bench for the bus pin controller.
  Assumes ebus_pkg and the memory model are compiled first.
*/
`include "ebus_defs.svh"

module ebus_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ebus_pkg::*;
  logic clk_in, rst_b_in, ready_in, rel_n, off_n, kwr, ken, mem_oe;
  logic grant_n, busy, done, kon, khold;
  logic [15:0] bus, last, rdata, kval, mem_data;
  logic [3:0] lag;
  bus_req_type req_in;
  bus_pins_type pins;
  int err_total, n_checks;
  ebus_ctrl DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req_in), .ready_in(ready_in),
    .bus_release_req_n_in(rel_n), .off_n_in(off_n), .keeper_wr_in(kwr), .bus_keeper_enable_in(ken),
    .ext_data_in(bus), .pins_out(pins), .bus_release_grant_n_out(grant_n), .busy_out(busy),
    .done_out(done), .rdata_out(rdata), .keeper_on_out(kon), .keeper_hold_en_out(khold),
    .keeper_hold_val_out(kval));
  ebus_mem_model mem (.clk_in(clk_in), .pins_in(pins), .data_in(bus), .lag_in(lag),
    .ready_out(ready_in), .mem_oe_out(mem_oe), .mem_data_out(mem_data));
  // ---------------------------------------------------------------
  // Bus resolution; a floating line wanders so it never looks held
  // ---------------------------------------------------------------
  always_comb begin
    if (pins.data_oe) bus = pins.ext_data;
    else if (mem_oe) bus = mem_data;
    else if (khold) bus = kval;
    else bus = ~last;
  end
  always @(posedge clk_in) last <= bus;
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic access(input space_type sp, input logic wr, vf, input logic [2:0] ws,
      input logic [22:0] a, input logic [15:0] wd, input logic [3:0] stall, input logic rel,
      output bus_pins_type s, output int n);
    @(posedge clk_in);
    lag <= {1'b0, ws} + stall;
    req_in <= '{1'b1, sp, wr, vf, ws, a, wd};
    @(posedge clk_in);
    req_in.valid <= 1'b0;
    if (rel) rel_n <= 1'b0;
    #1;
    s = pins;
    n = 0;
    chk("busy", 1, busy);
    while (done !== 1'b1 && n < 40) begin
      if (rel) chk("grant early", 1, grant_n);
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("done", 1, done);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_spaces();
    bus_pins_type s;
    int n;
    logic [2:0] sel;
    for (int i = 0; i < 3; i++) begin
      sel = (i == 1) ? 3'b011 : (i == 0) ? 3'b101 : 3'b110;
      access(space_type'(i), 1'b1, 1'b0, 3'h0, 23'h7c1230 + i, 16'h8001 ^ i, 4'h0, 1'b0, s, n);
      chk("hi oe", i == 0, s.addr_hi_oe);
      if (i == 0) chk("hi addr", 7'h7c, s.ext_addr[22:16]);
      chk("lo addr", 16'h1230 + i, s.ext_addr[15:0]);
      chk("selects", sel, {s.data_space_select_n, s.program_space_select_n, s.io_space_select_n});
      chk("strobes", (i == 2) ? 2'b10 : 2'b01, {s.memory_strobe_n, s.io_strobe_n});
      chk("wr dir", 0, s.read_write);
      chk("wr oe", 1, s.data_oe);
      chk("wr data", 16'h8001 ^ i, s.ext_data);
      access(space_type'(i), 1'b0, 1'b0, 3'h0, 23'h001230 + i, 16'h0, 4'h0, 1'b0, s, n);
      chk("rd data", 16'h8001 ^ i, rdata);
      chk("rd dir", 1, s.read_write);
      chk("rd oe", 0, s.data_oe);
      chk("idle sel", 3'b111, {pins.data_space_select_n, pins.program_space_select_n,
        pins.io_space_select_n});
    end
    $display("spaces done");
  endtask
  task automatic t_wait();
    bus_pins_type s;
    int n;
    logic [2:0] ws [5] = '{0, 1, 2, 2, 3};
    logic [3:0] st [5] = '{0, 2, 0, 2, 1};
    int exp [5] = '{1, 2, 3, 5, 5};
    for (int i = 0; i < 5; i++) begin
      access(SPACE_DATA, 1'b0, 1'b0, ws[i], 23'h40, 16'h0, st[i], 1'b0, s, n);
      chk("cycles", exp[i], n);
    end
    $display("wait done");
  endtask
  task automatic t_irq_acknowledge_n();
    bus_pins_type s;
    int n;
    access(SPACE_PROG, 1'b0, 1'b1, 3'h0, 23'h0000c0, 16'h0, 4'h0, 1'b0, s, n);
    chk("irq_acknowledge_n", 0, s.irq_acknowledge_n);
    chk("irq_acknowledge_n addr", 16'h00c0, s.ext_addr[15:0]);
    access(SPACE_PROG, 1'b0, 1'b0, 3'h0, 23'h0000c0, 16'h0, 4'h0, 1'b0, s, n);
    chk("no irq_acknowledge_n", 1, s.irq_acknowledge_n);
    $display("irq_acknowledge_n done");
  endtask
  task automatic t_release();
    bus_pins_type s;
    int n;
    access(SPACE_DATA, 1'b1, 1'b0, 3'h2, 23'h33, 16'h1111, 4'h1, 1'b1, s, n);
    chk("rel cycles", 4, n);
    @(posedge clk_in);
    #1;
    chk("grant", 0, grant_n);
    chk("float", 0, {pins.addr_lo_oe, pins.addr_hi_oe, pins.data_oe, pins.ctl_oe});
    chk("irq_acknowledge_n kept", 1, pins.irq_ack_oe);
    @(posedge clk_in);
    rel_n <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("regrant", 1, grant_n);
    $display("release done");
  endtask
  task automatic t_float();
    @(posedge clk_in);
    off_n <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("off oe", 0, {pins.addr_lo_oe, pins.addr_hi_oe, pins.data_oe, pins.ctl_oe});
    chk("off irq_acknowledge_n", 0, pins.irq_ack_oe);
    @(posedge clk_in);
    off_n <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("on oe", 1, pins.addr_lo_oe);
    $display("float done");
  endtask
  task automatic t_keeper();
    bus_pins_type s;
    int n;
    @(posedge clk_in);
    kwr <= 1'b1;
    ken <= 1'b1;
    @(posedge clk_in);
    kwr <= 1'b0;
    #1;
    chk("keeper on", 1, kon);
    access(SPACE_DATA, 1'b1, 1'b0, 3'h0, 23'h21, 16'h5a3c, 4'h0, 1'b0, s, n);
    repeat (3) @(posedge clk_in);
    #1;
    chk("hold en", 1, khold);
    chk("held bus", 16'h5a3c, bus);
    @(posedge clk_in);
    kwr <= 1'b1;
    ken <= 1'b0;
    @(posedge clk_in);
    kwr <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("hold off", 0, khold);
    $display("keeper done");
  endtask
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    n_checks = 0;
    rst_b_in = 1'b0;
    req_in = '0;
    rel_n = 1'b1;
    off_n = 1'b1;
    kwr = 1'b0;
    ken = 1'b0;
    lag = 4'h0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk("rst data oe", 0, pins.data_oe);
    chk("rst keeper", 0, kon);
    t_spaces();
    t_wait();
    t_irq_acknowledge_n();
    t_release();
    t_float();
    t_keeper();
    close_out();
  end
  initial begin
    #400us;
    err_total++;
    close_out();
  end
endmodule // ebus_ctrl_bench
